// ### rtl/eadp_top.sv
// external address detect port: link side tap, reject filter, apb registers
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module eadp_top (
  input  wire logic                        i_clk,
  input  wire logic                        i_resetn,
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [eadp_pkg::APB_AW-1:0] i_paddr,
  input  wire logic [31:0]                 i_pwdata,
  output logic      [31:0]                 o_prdata,
  output logic                             o_pready,
  output logic                             o_pslverr,
  input  wire logic                        i_link_clk,
  input  wire logic                        i_dec_rx_data,
  input  wire logic                        i_dec_rx_carrier,
  input  wire logic                        i_tst_rx_data,
  input  wire logic                        i_tst_rx_carrier,
  output logic                             o_serial_rx_clock,
  output logic                             o_serial_rx_data,
  output logic                             o_frame_byte_delimiter,
  input  wire logic                        i_external_reject_n,
  input  wire logic                        i_phys_match,
  input  wire logic                        i_logic_match,
  output logic                             o_frame_accept,
  output logic                             o_frame_discard,
  output logic                             o_dma_enable
);
  import eadp_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl;
  logic [15:0]       mode;
  logic [63:0]       laf;
  logic [1:0]        cfg_lvl;
  logic              in_frame;
  logic              rejected;
  logic              matched;
  logic              last_acc;
  logic              last_disc;
  logic [5:0]        rej_cnt;

  wire ap_setup  = i_psel & ~i_penable;
  wire ap_access = i_psel & i_penable & o_pready;
  wire ap_wr     = ap_access & i_pwrite;
  wire hit_ctrl  = (i_paddr == ADDR_CTRL);
  wire hit_mode  = (i_paddr == ADDR_MODE);
  wire hit_lafl  = (i_paddr == ADDR_LAF_LO);
  wire hit_lafh  = (i_paddr == ADDR_LAF_HI);
  wire hit_stat  = (i_paddr == ADDR_STATUS);
  wire hit_any   = hit_ctrl | hit_mode | hit_lafl | hit_lafh | hit_stat;

  wire        promisc   = mode[MODE_PROMISCUOUS_ENABLE];
  wire        ucast_dis = mode[MODE_UCDIS];
  wire        dma_ok    = ctrl[CTRL_START] & ~ctrl[CTRL_RXDIS];
  logic       sy_win;
  logic       sy_rej_n;
  wire [31:0] stat_val  = {26'h0000000, sy_win, o_dma_enable, last_disc, last_acc,
                           rejected, in_frame};
  wire [31:0] rd_val    = hit_ctrl ? {27'h0000000, ctrl} :
                          hit_mode ? {16'h0000, mode} :
                          hit_lafl ? laf[31:0] :
                          hit_lafh ? laf[63:32] :
                          hit_stat ? stat_val : 32'h00000000;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= 1'b1;
      o_pslverr <= ap_setup & ~hit_any;
      if (ap_setup) begin
        o_prdata <= rd_val;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl <= CTRL_RESET;
      mode <= MODE_RESET;
      laf  <= LAF_RESET;
    end else if (ap_wr) begin
      if (hit_ctrl) begin
        ctrl <= i_pwdata[CTRL_W-1:0];
      end
      if (hit_mode) begin
        mode <= i_pwdata[15:0];
      end
      if (hit_lafl) begin
        laf[31:0] <= i_pwdata;
      end
      if (hit_lafh) begin
        laf[63:32] <= i_pwdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // link domain tap
  // ---------------------------------------------------------------
  logic [1:0]     lk_cfg;
  logic           lk_ph;
  logic           lk_crs_q;
  logic           prev_bit;
  logic [2:0]     bit_cnt;
  logic [6:0]     byte_cnt;
  logic           win_open;
  logic           start_tgl;
  logic           end_tgl;
  eadp_state_type st;
  eadp_state_type next_st;

  eadp_sync #(.WIDTH(2)) u_cfg_sync (
    .i_clk    (i_link_clk),
    .i_resetn (i_resetn),
    .i_d      (cfg_lvl),
    .o_q      (lk_cfg)
  );

  wire lk_en    = lk_cfg[0];
  wire lk_tst   = lk_cfg[1];
  wire lk_bit   = lk_tst ? i_tst_rx_data : i_dec_rx_data;
  wire lk_crs   = lk_en & (lk_tst ? i_tst_rx_carrier : i_dec_rx_carrier);
  wire lk_smp   = lk_crs & ~lk_ph;
  wire sfd_hit  = lk_smp & (st == ST_PRE) & prev_bit & lk_bit;
  wire byte_hit = lk_smp & (st == ST_DATA) & (bit_cnt == 3'h7);
  wire win_end  = byte_hit & (byte_cnt == WINDOW_BYTES - 7'h01);
  wire fr_end   = lk_crs_q & ~lk_crs & (st == ST_DATA);

  always_comb begin
    next_st = st;
    case (st)
      ST_IDLE: begin
        if (lk_crs) begin
          next_st = ST_PRE;
        end
      end
      ST_PRE: begin
        if (!lk_crs) begin
          next_st = ST_IDLE;
        end else if (sfd_hit) begin
          next_st = ST_DATA;
        end
      end
      ST_DATA: begin
        if (!lk_crs) begin
          next_st = ST_IDLE;
        end
      end
      default: begin
        next_st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st                <= ST_IDLE;
      lk_ph             <= 1'b0;
      lk_crs_q          <= 1'b0;
      o_serial_rx_clock <= 1'b0;
    end else begin
      st                <= next_st;
      lk_ph             <= lk_crs & ~lk_ph;
      lk_crs_q          <= lk_crs;
      o_serial_rx_clock <= lk_crs & lk_ph;
    end
  end

  always_ff @(posedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_serial_rx_data       <= 1'b0;
      o_frame_byte_delimiter <= 1'b0;
      prev_bit               <= 1'b0;
    end else if (!lk_crs) begin
      o_frame_byte_delimiter <= 1'b0;
      prev_bit               <= 1'b0;
    end else if (lk_smp) begin
      o_serial_rx_data       <= lk_bit;
      o_frame_byte_delimiter <= sfd_hit | byte_hit;
      prev_bit               <= lk_bit;
    end
  end

  always_ff @(posedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bit_cnt   <= 3'h0;
      byte_cnt  <= 7'h00;
      win_open  <= 1'b0;
      start_tgl <= 1'b0;
      end_tgl   <= 1'b0;
    end else begin
      if (sfd_hit) begin
        bit_cnt   <= 3'h0;
        byte_cnt  <= 7'h00;
        start_tgl <= ~start_tgl;
      end else if (lk_smp && st == ST_DATA) begin
        bit_cnt <= bit_cnt + 3'h1;
        if (byte_hit && byte_cnt != WINDOW_BYTES) begin
          byte_cnt <= byte_cnt + 7'h01;
        end
      end
      if (sfd_hit) begin
        win_open <= 1'b1;
      end else if (win_end || !lk_crs) begin
        win_open <= 1'b0;
      end
      if (fr_end) begin
        end_tgl <= ~end_tgl;
      end
    end
  end

  // ---------------------------------------------------------------
  // crossings into the register clock
  // ---------------------------------------------------------------
  logic sy_start;
  logic sy_end;

  eadp_evt_sync u_start_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_toggle (start_tgl),
    .o_pulse  (sy_start)
  );

  eadp_evt_sync u_end_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_toggle (end_tgl),
    .o_pulse  (sy_end)
  );

  eadp_sync #(.WIDTH(2)) u_lvl_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_d      ({win_open, i_external_reject_n}),
    .o_q      ({sy_win, sy_rej_n})
  );

  // ---------------------------------------------------------------
  // reject filter and frame decision
  // ---------------------------------------------------------------
  wire rej_hit   = (rej_cnt == REJ_CYCLES);
  wire rej_set   = rej_hit & sy_win & in_frame & ~promisc;
  wire laf_any   = |laf;
  wire match_now = (i_phys_match & ~ucast_dis) | (i_logic_match & laf_any);
  wire keep      = promisc | matched | ~rejected;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rej_cnt <= 6'h00;
      cfg_lvl <= 2'h0;
    end else begin
      cfg_lvl <= {ctrl[CTRL_TST], ctrl[CTRL_SEL] & ctrl[CTRL_START]};
      if (sy_rej_n) begin
        rej_cnt <= 6'h00;
      end else if (!rej_hit) begin
        rej_cnt <= rej_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      in_frame <= 1'b0;
      rejected <= 1'b0;
      matched  <= 1'b0;
    end else begin
      if (sy_start) begin
        in_frame <= 1'b1;
      end else if (sy_end) begin
        in_frame <= 1'b0;
      end
      if (rej_set) begin
        rejected <= 1'b1;
      end else if (sy_start) begin
        rejected <= 1'b0;
      end
      if (match_now && in_frame) begin
        matched <= 1'b1;
      end else if (sy_start) begin
        matched <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_frame_accept  <= 1'b0;
      o_frame_discard <= 1'b0;
      o_dma_enable    <= 1'b0;
      last_acc        <= 1'b0;
      last_disc       <= 1'b0;
    end else begin
      o_dma_enable    <= dma_ok;
      o_frame_accept  <= sy_end & dma_ok & keep;
      o_frame_discard <= sy_end & dma_ok & ~keep;
      if (sy_end) begin
        last_acc  <= keep;
        last_disc <= ~keep;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [4:0] ast_gap;
  wire        gap_run  = lk_crs & (ast_gap != 5'h00) & (ast_gap != 5'h10);
  wire  [4:0] next_gap = sfd_hit ? 5'h01 : (gap_run ? ast_gap + 5'h01 : 5'h00);
  always_ff @(posedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ast_gap <= 5'h00;
    end else begin
      ast_gap <= next_gap;
    end
  end
  AST_SEL_GATE: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
    !lk_en |=> !o_serial_rx_clock && !o_frame_byte_delimiter)
    else $error("link outputs moved while port deselected");

  AST_CLK_IDLE: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
    !lk_crs |=> !o_serial_rx_clock [*2])
    else $error("serial clock toggled outside a frame");

  AST_SFD_DELIM: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
    sfd_hit |=> o_frame_byte_delimiter && st == ST_DATA)
    else $error("delimiter missing at start of frame");

  AST_BYTE_STROBE: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
    ast_gap == 5'h10 && lk_crs |=> o_frame_byte_delimiter)
    else $error("byte boundary strobe missing");

  AST_WINDOW: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
    win_end |=> !win_open && byte_cnt == WINDOW_BYTES)
    else $error("reject window did not close at byte limit");

  AST_REJ_WIDTH: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(rej_hit) |-> !$past(sy_rej_n, 8) && rej_cnt == REJ_CYCLES)
    else $error("reject accepted before minimum width");

  AST_MATCH_KEEP: assert property (@(posedge i_clk) disable iff (!i_resetn)
    sy_end && matched && dma_ok |=> o_frame_accept && !o_frame_discard)
    else $error("matched frame not accepted");

  AST_PROMISCUOUS_ENABLE: assert property (@(posedge i_clk) disable iff (!i_resetn)
    sy_end && promisc && dma_ok |=> o_frame_accept)
    else $error("promiscuous frame not accepted");

  AST_ONLY_EXT: assert property (@(posedge i_clk) disable iff (!i_resetn)
    sy_end && ucast_dis && !laf_any && rejected && !promisc |=> !o_frame_accept)
    else $error("rejected frame accepted with internal match off");

  AST_DISCARD: assert property (@(posedge i_clk) disable iff (!i_resetn)
    sy_end && rejected && !matched && !promisc && dma_ok |=> o_frame_discard)
    else $error("rejected frame not discarded");

  AST_DMA: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ctrl[CTRL_RXDIS] ##1 ctrl[CTRL_RXDIS] |-> !o_dma_enable && !o_frame_accept)
    else $error("delivery while receiver disabled");

endmodule // eadp_top
`default_nettype wire

// ### rtl/eadp_pkg.sv
// package: constants and types for the external address detect port
package eadp_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          APB_AW        = 8;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_MODE     = 8'h04;
  localparam logic [7:0]  ADDR_LAF_LO   = 8'h08;
  localparam logic [7:0]  ADDR_LAF_HI   = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS   = 8'h10;

  // bus_config_reg_two / control fields
  localparam int          CTRL_W        = 5;
  localparam int          CTRL_SEL      = 0;
  localparam int          CTRL_START    = 1;
  localparam int          CTRL_TXDIS    = 2;
  localparam int          CTRL_RXDIS    = 3;
  localparam int          CTRL_TST      = 4;
  localparam logic [4:0]  CTRL_RESET    = 5'h00;

  // mode_reg fields
  localparam int          MODE_PROMISCUOUS_ENABLE     = 15;
  localparam int          MODE_UCDIS    = 11;
  localparam logic [15:0] MODE_RESET    = 16'h0000;
  localparam logic [63:0] LAF_RESET     = 64'h0000000000000000;

  // status fields
  localparam int          STAT_INFRAME  = 0;
  localparam int          STAT_REJ      = 1;
  localparam int          STAT_ACC      = 2;
  localparam int          STAT_DISC     = 3;
  localparam int          STAT_DMA      = 4;
  localparam int          STAT_WIN      = 5;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          CLK_NS        = 4;
  localparam int          REJ_MIN_NS    = 200;
  localparam logic [5:0]  REJ_CYCLES    = 6'((REJ_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [6:0]  WINDOW_BYTES  = 7'h40;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PRE  = 3'b010,
    ST_DATA = 3'b100
  } eadp_state_type;

endpackage

// ### rtl/eadp_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module eadp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta <= '0;
      o_q  <= '0;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule // eadp_sync
`default_nettype wire

// ### rtl/eadp_evt_sync.sv
// toggle to pulse event crossing
`timescale 1ns/100ps
`default_nettype none
module eadp_evt_sync (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_toggle,
  output logic      o_pulse
);
  logic meta;
  logic sync;
  logic last;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta    <= 1'b0;
      sync    <= 1'b0;
      last    <= 1'b0;
      o_pulse <= 1'b0;
    end else begin
      meta    <= i_toggle;
      sync    <= meta;
      last    <= sync;
      o_pulse <= sync ^ last;
    end
  end
endmodule // eadp_evt_sync
`default_nettype wire

// ### verification/eadp_far_model.sv
// behavioural outside address filter: deserialises the tap and rejects a chosen byte
`timescale 1ns/100ps
`default_nettype none
module eadp_far_model (
  input  wire logic       i_clk,
  input  wire logic       i_srx_clk,
  input  wire logic       i_srx_data,
  input  wire logic       i_delim,
  input  wire logic [7:0] i_rej_at,
  input  wire logic [7:0] i_rej_len,
  output logic            o_reject_n,
  output logic [7:0]      o_first_byte
);
  logic [7:0] shreg     = 8'h00;
  logic [7:0] nbytes    = 8'h00;
  logic       seen      = 1'b0;
  logic       fire      = 1'b0;
  logic       fire_done = 1'b0;
  logic [7:0] idle_cnt  = 8'h00;
  logic [7:0] low_cnt   = 8'h00;
  initial o_reject_n = 1'b1;
  initial o_first_byte = 8'h00;
  // ---------------------------------------------------------------
  // deserialiser: bytes counted from the start-of-frame strobe
  // ---------------------------------------------------------------
  always @(posedge i_srx_clk) begin
    if (idle_cnt > 8'h28) begin
      seen = 1'b0;
      nbytes = 8'h00;
    end
    shreg = {i_srx_data, shreg[7:1]};
    if (i_delim && !seen) begin
      seen = 1'b1;
    end else if (i_delim) begin
      nbytes = nbytes + 8'h01;
      if (nbytes == 8'h01) begin
        o_first_byte = shreg;
      end
      if (nbytes == i_rej_at) begin
        fire = !fire;
      end
    end
  end
  // ---------------------------------------------------------------
  // reject pulse of the requested length in system cycles
  // ---------------------------------------------------------------
  always @(posedge i_clk) begin
    idle_cnt <= i_srx_clk ? 8'h00 : ((idle_cnt == 8'hFF) ? idle_cnt : idle_cnt + 8'h01);
    if (low_cnt != 8'h00) begin
      low_cnt <= low_cnt - 8'h01;
      o_reject_n <= (low_cnt == 8'h01);
    end else if (fire != fire_done) begin
      fire_done <= fire;
      low_cnt <= i_rej_len;
      o_reject_n <= 1'b0;
    end
  end
endmodule // eadp_far_model
`default_nettype wire

// ### verification/external_address_detect_port_test.sv
// self-checking bench for the external address detect port
`timescale 1ns/100ps
`default_nettype none
module external_address_detect_port_test;
  import eadp_pkg::*;
  logic clk = 1'b0, lclk = 1'b0, rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [APB_AW-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic dec_d = 1'b0, dec_c = 1'b0, tst_d = 1'b0, tst_c = 1'b0, phys = 1'b0, logm = 1'b0;
  logic srx_clk, srx_d, delim, rej_n, acc, disc, dma;
  logic [7:0] rej_at = 8'h00, rej_len = 8'h3C, first_b;
  int err_count = 0, check_count = 0, n_clk = 0, n_del = 0, n_acc = 0, n_dis = 0;

  always #2 clk = ~clk;
  initial begin
    #13;
    forever #32 lclk = ~lclk;
  end
  always @(posedge srx_clk) n_clk = n_clk + 1;
  always @(posedge delim) n_del = n_del + 1;
  always @(posedge clk) begin
    if (acc === 1'b1) n_acc = n_acc + 1;
    if (disc === 1'b1) n_dis = n_dis + 1;
  end

  eadp_top dut_u (.i_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_link_clk(lclk), .i_dec_rx_data(dec_d),
    .i_dec_rx_carrier(dec_c), .i_tst_rx_data(tst_d), .i_tst_rx_carrier(tst_c),
    .o_serial_rx_clock(srx_clk), .o_serial_rx_data(srx_d), .o_frame_byte_delimiter(delim),
    .i_external_reject_n(rej_n), .i_phys_match(phys), .i_logic_match(logm),
    .o_frame_accept(acc), .o_frame_discard(disc), .o_dma_enable(dma));
  eadp_far_model far_u (.i_clk(clk), .i_srx_clk(srx_clk), .i_srx_data(srx_d),
    .i_delim(delim), .i_rej_at(rej_at), .i_rej_len(rej_len), .o_reject_n(rej_n),
    .o_first_byte(first_b));

  task automatic wrap_up;
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      err_count++;
      wrap_up;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic cfg(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (4) @(posedge lclk);
    @(posedge clk);
  endtask
  // preamble 1,0,1,0,1,0 then 1,1, then bytes least significant bit first
  task automatic send(input logic [7:0] b0, input int n, input logic tst);
    logic bv;
    logic [7:0] b;
    for (int i = -8; i < 8 * n; i++) begin
      b = (i < 8) ? b0 : 8'(i / 8);
      bv = (i < 0) ? ((i >= -2) || ((i % 2) == 0)) : b[i % 8];
      @(posedge lclk);
      if (tst) begin tst_c <= 1'b1; tst_d <= bv; end
      else begin dec_c <= 1'b1; dec_d <= bv; end
      @(posedge lclk);
    end
    @(posedge lclk);
    dec_c <= 1'b0; tst_c <= 1'b0; dec_d <= ~dec_d; tst_d <= ~tst_d;
    repeat (3) @(posedge lclk);
    @(posedge clk);
  endtask
  task automatic run_case(input string what, input logic [7:0] b0, input int n,
                          input logic [7:0] at, input logic [7:0] len, input logic ph,
                          input logic lg, input logic tst, input logic exp_acc);
    int k;
    rej_at <= at; rej_len <= len; phys <= ph; logm <= lg;
    n_clk = 0; n_del = 0; n_acc = 0; n_dis = 0;
    send(b0, n, tst);
    k = 0;
    while (n_acc + n_dis == 0 && k < 400) begin
      @(posedge clk);
      k++;
    end
    if (k >= 400) begin
      err_count++;
      wrap_up;
    end
    chk({what, " accept"}, 32'(exp_acc), 32'(n_acc));
    chk({what, " discard"}, 32'(!exp_acc), 32'(n_dis));
    chk({what, " strobes"}, 32'(n + 1), 32'(n_del));
    chk({what, " bit clocks"}, 32'(8 * n + 8), 32'(n_clk));
    chk({what, " first byte"}, 32'(b0), 32'(first_b));
    phys <= 1'b0; logm <= 1'b0; rej_at <= 8'h00;
  endtask

  initial begin
    int k;
    repeat (6) @(posedge clk);
    repeat (2) @(posedge lclk);
    @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, ADDR_MODE, 32'h0);
    chk("mode reset", 32'h0, rd);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status reset", 32'h0, rd);
    apb(1'b1, 8'h14, 32'hFFFFFFFF);
    chk("unmapped write err", 32'h1, 32'(err));
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped read data", 32'h0, rd);
    cfg(ADDR_CTRL, 32'h2);
    n_clk = 0; n_del = 0;
    send(8'h11, 4, 1'b0);
    chk("deselected strobes", 32'h0, 32'(n_del));
    chk("deselected clocks", 32'h0, 32'(n_clk));
    cfg(ADDR_CTRL, 32'h3);
    chk("dma on", 32'h1, 32'(dma));
    run_case("plain", 8'h5A, 8, 8'h00, 8'h3C, 1'b0, 1'b0, 1'b0, 1'b1);
    run_case("rejected", 8'hC3, 14, 8'h07, 8'h3C, 1'b0, 1'b0, 1'b0, 1'b0);
    run_case("phys hit", 8'h21, 8, 8'h01, 8'h3C, 1'b1, 1'b0, 1'b0, 1'b1);
    run_case("short pulse", 8'h42, 8, 8'h01, 8'h14, 1'b0, 1'b0, 1'b0, 1'b1);
    run_case("late reject", 8'h99, 70, 8'h42, 8'h3C, 1'b0, 1'b0, 1'b0, 1'b1);
    cfg(ADDR_MODE, 32'h8000);
    apb(1'b0, ADDR_MODE, 32'h0);
    chk("mode readback", 32'h8000, rd);
    run_case("promiscuous", 8'h0F, 8, 8'h01, 8'h3C, 1'b0, 1'b0, 1'b0, 1'b1);
    cfg(ADDR_MODE, 32'h0800);
    run_case("unicast off", 8'hE7, 8, 8'h01, 8'h3C, 1'b1, 1'b0, 1'b0, 1'b0);
    cfg(ADDR_MODE, 32'h0);
    cfg(ADDR_LAF_LO, 32'h1);
    run_case("logical hit", 8'h81, 8, 8'h01, 8'h3C, 1'b0, 1'b1, 1'b0, 1'b1);
    cfg(ADDR_LAF_LO, 32'h0);
    cfg(ADDR_CTRL, 32'h13);
    run_case("test port", 8'hB4, 8, 8'h00, 8'h3C, 1'b0, 1'b0, 1'b1, 1'b1);
    cfg(ADDR_CTRL, 32'h0F);
    chk("dma halted", 32'h0, 32'(dma));
    rej_at <= 8'h01;
    n_del = 0;
    n_acc = 0;
    n_dis = 0;
    send(8'h3C, 8, 1'b0);
    k = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      k++;
    end while (rd[STAT_DISC] !== 1'b1 && k < 50);
    chk("halted discard", 32'h1, 32'(rd[STAT_DISC]));
    chk("halted strobes", 32'h9, 32'(n_del));
    chk("halted pulses", 32'h0, 32'(n_acc + n_dis));
    wrap_up;
  end
endmodule // external_address_detect_port_test
`default_nettype wire
